// *** hdl/pwwd_pkg.sv ***
// constants and types of the clock synthesiser and watchdog block
// assumes a 100 MHz mclk and word-aligned AHB-Lite register offsets
package pwwd_pkg;

  localparam logic [7:0] A_SYNTH  = 8'h00;
  localparam logic [7:0] A_WDCTL  = 8'h04;
  localparam logic [7:0] A_WDSVC  = 8'h08;
  localparam logic [7:0] A_STAT   = 8'h0C;
  localparam logic [7:0] A_IRQCLR = 8'h10;
  localparam logic [7:0] A_IRQEN  = 8'h14;
  localparam logic [7:0] A_PLLHZ  = 8'h18;
  localparam logic [7:0] A_BUSHZ  = 8'h1C;
  localparam logic [7:0] A_WDCNT  = 8'h20;

  localparam int SY_REF_LSB  = 0;
  localparam int SY_SYN_LSB  = 8;
  localparam int SY_POST_LSB = 16;
  localparam int SY_EXT_OSC_ENABLE_BIT = 24;
  localparam int SY_SEL_BIT  = 25;
  localparam int WD_WIN_BIT  = 7;
  localparam int WD_CLO_BIT  = 8;
  localparam int WD_CHI_BIT  = 9;
  localparam int WD_STOP_WD_CLOCK_DISABLE_BIT = 10;
  localparam int WD_MASK_BIT = 31;
  localparam int ST_LOCK_BIT = 8;

  localparam int IRQ_TMO  = 0;
  localparam int IRQ_CODE = 1;
  localparam int IRQ_WIN  = 2;
  localparam int IRQ_LVR  = 3;
  localparam int IRQ_W    = 4;

  localparam logic [7:0]  SVC_ARM   = 8'h55;
  localparam logic [7:0]  SVC_FIRE  = 8'hAA;
  localparam logic [2:0]  WD_OFF    = 3'h0;
  localparam logic [3:0]  REFERENCE_DIVIDER_RST  = 4'h0;
  localparam logic [5:0]  FEEDBACK_MULTIPLIER_RST  = 6'h00;
  localparam logic [4:0]  OUTPUT_POST_DIVIDER_RST = 5'h00;

  localparam logic [31:0] CLK_HZ     = 32'h05F5_E100;
  localparam logic [31:0] IRC_HZ     = 32'h000F_4240;
  localparam logic [31:0] OSC_HZ_DEF = 32'h007A_1200;
  localparam logic [31:0] UNLOCK_DIV = 32'h0000_0004;
  localparam logic [31:0] BUS_DIV    = 32'h0000_0002;
  localparam logic [6:0]  IRC_DIV_CYC = 7'(CLK_HZ / IRC_HZ);
  localparam int unsigned WD_SHIFT_BASE = 8;

  typedef enum logic {WS_IDLE, WS_ARMED} pwwd_svc_t;

endpackage

// *** hdl/pwwd_synth_if.sv ***
// synthesiser settings and computed frequencies between top and calculator
// assumes both ends sit on mclk
`timescale 1ns/1ps
interface pwwd_synth_if;
  logic [3:0]  reference_divider;
  logic [5:0]  feedback_multiplier;
  logic [4:0]  output_post_divider;
  logic        osc_en;
  logic        lock;
  logic        pll_sel;
  logic [31:0] ref_hz;
  logic [31:0] pll_hz;
  logic [31:0] bus_hz;
  modport calc (input reference_divider, feedback_multiplier, output_post_divider, osc_en, lock, pll_sel,
                output ref_hz, pll_hz, bus_hz);
  modport ctrl (output reference_divider, feedback_multiplier, output_post_divider, osc_en, lock, pll_sel,
                input ref_hz, pll_hz, bus_hz);
endinterface

// *** hdl/pwwd_synth_calc.sv ***
// frequency model of the clock synthesiser, figures in Hz
// assumes settings come from flops on mclk
`timescale 1ns/1ps
module pwwd_synth_calc #(
  parameter logic [31:0] OSC_HZ = pwwd_pkg::OSC_HZ_DEF
) (
  input  logic         mclk,
  input  logic         rst_n,
  pwwd_synth_if.calc   s
);
  import pwwd_pkg::*;

  logic [31:0] nxt_ref;
  logic [31:0] nxt_vco;
  logic [31:0] nxt_pll;
  logic [31:0] nxt_bus;
  logic [31:0] ref_ff;
  logic [31:0] pll_ff;
  logic [31:0] bus_ff;

  assign nxt_ref = s.osc_en ? OSC_HZ / ({28'h0, s.reference_divider} + 32'h1)
                            : IRC_HZ;
  // vco may wrap for absurd settings; bus limit is software's
  assign nxt_vco = (nxt_ref << 1) * ({26'h0, s.feedback_multiplier} + 32'h1);
  assign nxt_pll = s.lock ? nxt_vco / ({27'h0, s.output_post_divider} + 32'h1)
                          : nxt_vco / UNLOCK_DIV;
  assign nxt_bus = s.pll_sel ? nxt_pll / BUS_DIV
                             : OSC_HZ / BUS_DIV;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ref_ff <= IRC_HZ;
      pll_ff <= 32'h0000_0000;
      bus_ff <= 32'h0000_0000;
    end else begin
      ref_ff <= nxt_ref;
      pll_ff <= nxt_pll;
      bus_ff <= nxt_bus;
    end
  end

  assign s.ref_hz = ref_ff;
  assign s.pll_hz = pll_ff;
  assign s.bus_hz = bus_ff;

  ////////////////////////////////////////////////////////////////////////////
  property p_ref_irc;
    @(posedge mclk) disable iff (!rst_n)
    !s.osc_en |=> s.ref_hz == IRC_HZ;
  endproperty
  a_ref_irc: assert property (p_ref_irc)
    else $error("reference not internal rc");

  property p_ref_div;
    @(posedge mclk) disable iff (!rst_n)
    s.osc_en |=> s.ref_hz == OSC_HZ / ({28'h0, $past(s.reference_divider)} + 32'h1);
  endproperty
  a_ref_div: assert property (p_ref_div)
    else $error("reference divide wrong");

  property p_unlock;
    @(posedge mclk) disable iff (!rst_n)
    !s.lock |=> s.pll_hz == $past(nxt_vco) / 32'h0000_0004;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("unlocked output not vco over four");

  property p_bus_half;
    @(posedge mclk) disable iff (!rst_n)
    s.pll_sel |=> s.bus_hz == (s.pll_hz >> 1);
  endproperty
  a_bus_half: assert property (p_bus_half)
    else $error("bus not half of synth output");

endmodule // pwwd_synth_calc

// *** hdl/pwwd_top.sv ***
// clock synthesiser control, window watchdog and supply reset gathering
// assumes one 100 MHz clock, sync reset, inputs synchronous to mclk
//
// Overview of operation
// - with external oscillator off the reference is the 1MHz internal rc.
// - with oscillator on, reference is oscillator over divider plus one.
// - stage frequency is twice reference times multiplier field plus one.
// - when locked, output is stage clock over post divider plus one.
// - when unlocked, output is stage clock over fixed four.
// - with synth selected, bus clock is half the synth output.
// - three-bit period field picks seven time-outs or off.
// - expiry without a complete service sequence causes watchdog reset.
// - while the watchdog runs, any service write other than the two codes resets at once.
// - window mode accepts service only in last quarter; earlier resets.
// - normal mode preloads period and window at release; default off.
// - normal mode control accepts one update; off refused if preloaded on.
// - clock source is not preloaded; internal rc after reset.
// - clock selects and stop disable freeze after the single update.
// - masked control writes skip period and window and keep update.
// - power-on detector always acts, standing in for low-voltage in stop.
// - low-voltage reset watches three rails, only in run and wait.
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module pwwd_top #(
  parameter int unsigned WD_SHIFT = pwwd_pkg::WD_SHIFT_BASE,
  parameter logic [31:0] OSC_HZ   = pwwd_pkg::OSC_HZ_DEF
) (
  input  logic        mclk,
  input  logic        rst_n,
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic [31:0] hwdata,
  input  logic        hready,
  output logic        hreadyout,
  output logic        hresp,
  output logic [31:0] hrdata,
  input  logic        pll_lock,
  input  logic        ext_osc_tick,
  input  logic        aclk_tick,
  input  logic        normal_mode,
  input  logic        stop_mode,
  input  logic        nvm_valid,
  input  logic [2:0]  nvm_period,
  input  logic        nvm_window,
  input  logic        por_low,
  input  logic        vdd_low,
  input  logic        vddx_low,
  input  logic        vddf_low,
  output logic        irq,
  output logic        wd_reset,
  output logic        sys_reset_req,
  output logic [31:0] bus_clock_hz
);
  import pwwd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: writes zero wait, reads one wait state
  logic        ap;
  logic [7:0]  addr_ff;
  logic        wr_ff;
  logic        rd_wait_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] rd_mux;

  assign ap        = hsel & htrans[1] & hready;
  assign hreadyout = !rd_wait_ff;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      addr_ff    <= 8'h00;
      wr_ff      <= 1'b0;
      rd_wait_ff <= 1'b0;
    end else begin
      if (ap) begin
        addr_ff <= haddr[7:0];
      end
      wr_ff      <= ap & hwrite;
      rd_wait_ff <= ap & !hwrite;
    end
  end

  // read sampled in the wait cycle so a write just before is seen
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (rd_wait_ff) begin
      hrdata_ff <= rd_mux;
    end
  end

  logic syn_hit;
  logic ctl_hit;
  logic svc_wr;
  logic clr_hit;
  logic en_hit;

  assign syn_hit = wr_ff & (addr_ff == A_SYNTH);
  assign ctl_hit = wr_ff & (addr_ff == A_WDCTL);
  assign svc_wr  = wr_ff & (addr_ff == A_WDSVC);
  assign clr_hit = wr_ff & (addr_ff == A_IRQCLR);
  assign en_hit  = wr_ff & (addr_ff == A_IRQEN);

  ////////////////////////////////////////////////////////////////////////////
  // synthesiser settings
  logic [3:0] reference_divider_ff;
  logic [5:0] feedback_multiplier_ff;
  logic [4:0] output_post_divider_ff;
  logic       ext_osc_enable_ff;
  logic       sel_ff;
  logic       nxt_ext_osc_enable;

  assign nxt_ext_osc_enable = hwdata[SY_EXT_OSC_ENABLE_BIT];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reference_divider_ff  <= REFERENCE_DIVIDER_RST;
      feedback_multiplier_ff  <= FEEDBACK_MULTIPLIER_RST;
      output_post_divider_ff <= OUTPUT_POST_DIVIDER_RST;
      ext_osc_enable_ff    <= 1'b0;
      sel_ff     <= 1'b1;
    end else if (syn_hit) begin
      reference_divider_ff  <= hwdata[SY_REF_LSB +: 4];
      feedback_multiplier_ff  <= hwdata[SY_SYN_LSB +: 6];
      output_post_divider_ff <= hwdata[SY_POST_LSB +: 5];
      ext_osc_enable_ff    <= nxt_ext_osc_enable;
      // oscillator path only selectable while the oscillator runs
      sel_ff     <= hwdata[SY_SEL_BIT] | !nxt_ext_osc_enable;
    end
  end

  pwwd_synth_if sy ();
  assign sy.reference_divider  = reference_divider_ff;
  assign sy.feedback_multiplier  = feedback_multiplier_ff;
  assign sy.output_post_divider = output_post_divider_ff;
  assign sy.osc_en  = ext_osc_enable_ff;
  assign sy.lock    = pll_lock;
  assign sy.pll_sel = sel_ff;
  assign bus_clock_hz = sy.bus_hz;

  pwwd_synth_calc #(.OSC_HZ(OSC_HZ)) u_calc (
    .mclk  (mclk),
    .rst_n (rst_n),
    .s     (sy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // internal rc tick, 1 MHz enable
  logic [6:0] irc_cnt_ff;
  logic       irc_tick;

  assign irc_tick = (irc_cnt_ff == IRC_DIV_CYC - 7'h01);

  always_ff @(posedge mclk) begin
    if (!rst_n || irc_tick) begin
      irc_cnt_ff <= 7'h00;
    end else begin
      irc_cnt_ff <= irc_cnt_ff + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog control
  logic [2:0] per_ff;
  logic       win_ff;
  logic       clo_ff;
  logic       chi_ff;
  logic       stop_wd_clock_disable_ff;
  logic       once_ff;
  logic       pre_on_ff;
  logic       load_ff;
  logic       frozen;
  logic       upd;
  logic [2:0] new_per;

  assign frozen  = normal_mode & once_ff;
  assign upd     = ctl_hit & !hwdata[WD_MASK_BIT] & !frozen;
  // off code refused when preload had enabled the watchdog
  assign new_per = (pre_on_ff && hwdata[2:0] == WD_OFF) ? per_ff
                                                        : hwdata[2:0];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      per_ff    <= WD_OFF;
      win_ff    <= 1'b0;
      pre_on_ff <= 1'b0;
      once_ff   <= 1'b0;
      load_ff   <= 1'b1;
    end else if (load_ff) begin
      load_ff <= 1'b0;
      if (normal_mode && nvm_valid) begin
        per_ff    <= nvm_period;
        win_ff    <= nvm_window;
        pre_on_ff <= (nvm_period != WD_OFF);
      end
    end else if (upd) begin
      per_ff  <= new_per;
      win_ff  <= hwdata[WD_WIN_BIT];
      once_ff <= normal_mode;
    end
  end

  logic chi_change;
  assign chi_change = ctl_hit & !frozen & (hwdata[WD_CHI_BIT] != chi_ff);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      clo_ff  <= 1'b0;
      chi_ff  <= 1'b0;
      stop_wd_clock_disable_ff <= 1'b0;
    end else if (ctl_hit && !frozen) begin
      clo_ff  <= hwdata[WD_CLO_BIT];
      chi_ff  <= hwdata[WD_CHI_BIT];
      stop_wd_clock_disable_ff <= hwdata[WD_STOP_WD_CLOCK_DISABLE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog counter and service sequence
  function automatic logic [23:0] wd_limit(input logic [2:0] code);
    logic [23:0] f;
    f = 24'h00_0000;
    if (code != WD_OFF) begin
      f = 24'h00_0001 << (WD_SHIFT + 2 * (32'(code) - 1));
    end
    return f;
  endfunction

  logic [23:0] lim;
  logic [23:0] win_open;
  logic [23:0] wd_cnt_ff;
  logic        wd_on;
  logic        wd_tick;
  logic        tmo;
  logic        bad_code;
  logic        early;
  logic        svc_fault;
  logic        restart;
  logic        wd_rst_ff;
  pwwd_svc_t   svc_ff;
  pwwd_svc_t   nxt_svc;

  assign lim      = wd_limit(per_ff);
  assign win_open = wd_limit(per_ff) - (wd_limit(per_ff) >> 2);
  assign wd_on    = (per_ff != WD_OFF) & !load_ff;
  // stop_wd_clock_disable stops the count only while in stop mode
  assign wd_tick  = !(stop_mode & stop_wd_clock_disable_ff) &
                    (chi_ff ? aclk_tick : (clo_ff ? ext_osc_tick : irc_tick));
  assign tmo      = wd_on & wd_tick & (wd_cnt_ff == lim - 24'h00_0001);
  assign bad_code = hwdata[7:0] != SVC_ARM && hwdata[7:0] != SVC_FIRE;
  assign early    = win_ff & (wd_cnt_ff < win_open);
  assign svc_fault = svc_wr & wd_on & (bad_code | early);
  assign restart  = svc_wr & wd_on & !svc_fault & (svc_ff == WS_ARMED)
                  & (hwdata[7:0] == SVC_FIRE);

  always_comb begin
    nxt_svc = svc_ff;
    if (svc_wr && wd_on && !svc_fault) begin
      nxt_svc = (hwdata[7:0] == SVC_ARM) ? WS_ARMED : WS_IDLE;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      svc_ff    <= WS_IDLE;
      wd_cnt_ff <= 24'h00_0000;
      wd_rst_ff <= 1'b0;
    end else begin
      svc_ff    <= (tmo | svc_fault) ? WS_IDLE : nxt_svc;
      wd_rst_ff <= tmo | svc_fault;
      if (!wd_on || tmo || svc_fault || restart || chi_change || upd) begin
        wd_cnt_ff <= 24'h00_0000;
      end else if (wd_tick) begin
        wd_cnt_ff <= wd_cnt_ff + 24'h00_0001;
      end
    end
  end

  assign wd_reset = wd_rst_ff;

  ////////////////////////////////////////////////////////////////////////////
  // supply monitors
  logic lvr_act;
  logic rst_req_ff;

  assign lvr_act = !stop_mode & (vdd_low | vddx_low | vddf_low);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rst_req_ff <= 1'b0;
    end else begin
      rst_req_ff <= por_low | lvr_act | wd_rst_ff;
    end
  end

  assign sys_reset_req = rst_req_ff;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, set beats clear
  logic [IRQ_W-1:0] stat_ff;
  logic [IRQ_W-1:0] irq_en_ff;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;

  assign ev  = {lvr_act, svc_fault & early, svc_fault & bad_code, tmo};
  assign clr = clr_hit ? hwdata[IRQ_W-1:0] : '0;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stat_ff   <= '0;
      irq_en_ff <= '0;
    end else begin
      stat_ff <= (stat_ff & ~clr) | ev;
      if (en_hit) begin
        irq_en_ff <= hwdata[IRQ_W-1:0];
      end
    end
  end

  assign irq = |(stat_ff & irq_en_ff);

  ////////////////////////////////////////////////////////////////////////////
  // read selection
  logic [31:0] syn_rd;
  logic [31:0] ctl_rd;
  logic [31:0] st_rd;

  assign syn_rd = {6'h00, sel_ff, ext_osc_enable_ff, 3'h0, output_post_divider_ff,
                   2'h0, feedback_multiplier_ff, 4'h0, reference_divider_ff};
  assign ctl_rd = {21'h00_0000, stop_wd_clock_disable_ff, chi_ff, clo_ff, win_ff,
                   4'h0, per_ff};
  assign st_rd  = {23'h00_0000, pll_lock, 4'h0, stat_ff};

  assign rd_mux = (addr_ff == A_SYNTH) ? syn_rd :
                  (addr_ff == A_WDCTL) ? ctl_rd :
                  (addr_ff == A_STAT)  ? st_rd :
                  (addr_ff == A_IRQEN) ? {28'h000_0000, irq_en_ff} :
                  (addr_ff == A_PLLHZ) ? sy.pll_hz :
                  (addr_ff == A_BUSHZ) ? sy.bus_hz :
                  (addr_ff == A_WDCNT) ? {8'h00, wd_cnt_ff} :
                  32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  property p_tmo;
    @(posedge mclk) disable iff (!rst_n)
    wd_on && wd_tick && wd_cnt_ff == lim - 24'h00_0001
      |=> wd_reset && stat_ff[IRQ_TMO] ##1 sys_reset_req;
  endproperty
  a_tmo: assert property (p_tmo)
    else $error("timeout gave no watchdog reset");

  property p_bad;
    @(posedge mclk) disable iff (!rst_n)
    svc_wr && wd_on && hwdata[7:0] != 8'h55 && hwdata[7:0] != 8'hAA
      |=> wd_reset && wd_cnt_ff == 24'h00_0000;
  endproperty
  a_bad: assert property (p_bad)
    else $error("bad service code not reset");

  property p_early;
    @(posedge mclk) disable iff (!rst_n)
    svc_wr && wd_on && win_ff && wd_cnt_ff < win_open |=> wd_reset;
  endproperty
  a_early: assert property (p_early)
    else $error("early window service not reset");

  property p_preload;
    @(posedge mclk) disable iff (!rst_n)
    load_ff && normal_mode && nvm_valid
      |=> per_ff == $past(nvm_period) && win_ff == $past(nvm_window);
  endproperty
  a_preload: assert property (p_preload)
    else $error("preload not taken");

  property p_once;
    @(posedge mclk) disable iff (!rst_n)
    normal_mode && once_ff && ctl_hit
      |=> $stable(per_ff) && $stable(win_ff) && $stable(chi_ff);
  endproperty
  a_once: assert property (p_once)
    else $error("control changed after single update");

  property p_mask;
    @(posedge mclk) disable iff (!rst_n)
    ctl_hit && hwdata[31] && !load_ff |=> $stable(per_ff) && $stable(once_ff);
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked write altered period");

  property p_por;
    @(posedge mclk) disable iff (!rst_n)
    por_low |=> sys_reset_req;
  endproperty
  a_por: assert property (p_por)
    else $error("power-on reset ignored");

  property p_stop_lvr;
    @(posedge mclk) disable iff (!rst_n)
    stop_mode && !por_low && !wd_rst_ff |=> !sys_reset_req;
  endproperty
  a_stop_lvr: assert property (p_stop_lvr)
    else $error("low-voltage reset active in stop");

  c_tmo: cover property (@(posedge mclk) disable iff (!rst_n) tmo);
  c_svc: cover property (@(posedge mclk) disable iff (!rst_n) restart);
  c_load: cover property (@(posedge mclk) disable iff (!rst_n)
                          load_ff && normal_mode && nvm_valid);

endmodule // pwwd_top

// *** sim/pll_and_window_watchdog_bench.sv ***
// self-checking bench for the synthesiser and window watchdog block
// assumes pwwd_top alone, driven over AHB-Lite by the tasks below
`timescale 1ns/1ps
module pll_and_window_watchdog_bench import pwwd_pkg::*;;
  localparam logic [31:0] OSC = 32'h0098_9680;
  logic        mclk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, bus_clock_hz, n_wdr, rd, ex;
  logic [1:0]  htrans;
  logic [2:0]  hsize, nvm_period;
  logic        pll_lock, ext_osc_tick, aclk_tick, normal_mode, stop_mode;
  logic        nvm_valid, nvm_window, por_low, vdd_low, vddx_low, vddf_low;
  logic        irq, wd_reset, sys_reset_req;
  logic [7:0]  tcnt;
  logic [25:0] cfg [5];
  logic        lks [5];
  int          n_errors, checked;
  assign hready = hreadyout;
  pwwd_top #(.WD_SHIFT(2), .OSC_HZ(OSC)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pll_lock(pll_lock), .ext_osc_tick(ext_osc_tick),
    .aclk_tick(aclk_tick), .normal_mode(normal_mode),
    .stop_mode(stop_mode), .nvm_valid(nvm_valid),
    .nvm_period(nvm_period), .nvm_window(nvm_window), .por_low(por_low),
    .vdd_low(vdd_low), .vddx_low(vddx_low), .vddf_low(vddf_low),
    .irq(irq), .wd_reset(wd_reset), .sys_reset_req(sys_reset_req),
    .bus_clock_hz(bus_clock_hz));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // free-running tick sources so no watchdog clock input is left tied
  always @(posedge mclk) begin
    tcnt <= tcnt + 8'h01;
    ext_osc_tick <= (tcnt % 3 == 0);
    aclk_tick <= (tcnt[2:0] == 3'h0);
    if (wd_reset === 1'b1) n_wdr <= n_wdr + 32'h0000_0001;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // samples hready in the low half so the edge value is seen race-free
  task automatic ahb_wait(output logic [31:0] d);
    int k;
    logic r;
    k = 0;
    r = 1'b0;
    while (!r) begin
      @(negedge mclk);
      r = (hreadyout === 1'b1);
      d = hrdata;
      @(posedge mclk);
      k++;
      if (k > 50) begin
        n_errors++;
        $display("unexpected hang at %0t: got %h expected %h", $time, 0, 1);
        conclude();
      end
    end
  endtask
  task automatic ahb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    ahb_wait(q);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    ahb_wait(q);
    chk1(hresp, 1'b0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(a, 1'b1, d, rd);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    ahb(a, 1'b0, 32'h0000_0000, rd);
    chk32(rd & m, exp);
  endtask
  task automatic wait_wdr(input int bound);
    logic [31:0] n0;
    n0 = n_wdr;
    for (int i = 0; i < bound && n_wdr === n0; i++) @(posedge mclk);
    chk32(n_wdr, n0 + 32'h0000_0001);
  endtask
  task automatic do_reset(input logic nm, input logic nv,
                          input logic [2:0] np, input logic nw);
    @(posedge mclk);
    rst_n <= 1'b0;
    normal_mode <= nm;
    nvm_valid <= nv;
    nvm_period <= np;
    nvm_window <= nw;
    wait_cyc(4);
    rst_n <= 1'b1;
  endtask
  function automatic logic [31:0] f_pll(input logic [25:0] c, input logic lk);
    logic [31:0] rf, vco;
    rf = c[SY_EXT_OSC_ENABLE_BIT] ? OSC / (32'(c[3:0]) + 1) : IRC_HZ;
    vco = 2 * rf * (32'(c[13:8]) + 1);
    return lk ? vco / (32'(c[20:16]) + 1) : vco / UNLOCK_DIV;
  endfunction
  //////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, hsel, hwrite, htrans, haddr, hwdata, pll_lock} = '0;
    {stop_mode, por_low, vdd_low, vddx_low, vddf_low, tcnt} = '0;
    {ext_osc_tick, aclk_tick, n_wdr} = '0;
    hsize = 3'h2;
    // irc ref ignores reference_divider; then osc paths, unlocked, and osc bus
    cfg = '{26'h200_0005, 26'h301_0503, 26'h31F_3F0F, 26'h309_0702,
            26'h102_0401};
    lks = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    do_reset(1'b1, 1'b0, 3'h0, 1'b0);
    rd_chk(A_WDCTL, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_chk(A_STAT, 32'h0000_000F, 32'h0000_0000);
    rd_chk(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(A_WDSVC, 32'h0000_0012);
    wait_cyc(3);
    chk32(n_wdr, 32'h0000_0000);
    for (int i = 0; i < 5; i++) begin
      wr(A_SYNTH, {6'h00, cfg[i]});
      pll_lock <= lks[i];
      wait_cyc(4);
      ex = f_pll(cfg[i], lks[i]);
      rd_chk(A_PLLHZ, '1, ex);
      ex = cfg[i][SY_SEL_BIT] ? f_pll(cfg[i], lks[i]) / BUS_DIV
                              : OSC / BUS_DIV;
      rd_chk(A_BUSHZ, '1, ex);
      chk32(bus_clock_hz, rd);
    end
    pll_lock <= 1'b0;
    // supply monitors, then the interrupt path on the lvr event
    vdd_low <= 1'b1;
    wait_cyc(3);
    @(negedge mclk);
    chk1(sys_reset_req, 1'b1);
    @(posedge mclk);
    vdd_low <= 1'b0;
    vddf_low <= 1'b1;
    wait_cyc(3);
    @(negedge mclk);
    chk1(sys_reset_req, 1'b1);
    @(posedge mclk);
    vddf_low <= 1'b0;
    stop_mode <= 1'b1;
    vddx_low <= 1'b1;
    wait_cyc(3);
    @(negedge mclk);
    chk1(sys_reset_req, 1'b0);
    @(posedge mclk);
    por_low <= 1'b1;
    wait_cyc(3);
    @(negedge mclk);
    chk1(sys_reset_req, 1'b1);
    @(posedge mclk);
    {por_low, vddx_low, stop_mode} <= 3'h0;
    rd_chk(A_STAT, 32'h0000_000F, 32'h0000_0008);
    wr(A_IRQEN, 32'h0000_0008);
    @(negedge mclk);
    chk1(irq, 1'b1);
    wr(A_IRQEN, 32'h0000_0000);
    @(negedge mclk);
    chk1(irq, 1'b0);
    wr(A_IRQEN, 32'h0000_000F);
    wr(A_IRQCLR, 32'h0000_000F);
    @(negedge mclk);
    chk1(irq, 1'b0);
    // masked write keeps the update; clock bits still taken
    wr(A_WDCTL, 32'h8000_0103);
    rd_chk(A_WDCTL, 32'hFFFF_FFFF, 32'h0000_0100);
    wr(A_WDCTL, 32'h0000_0001);
    rd_chk(A_WDCTL, 32'hFFFF_FFFF, 32'h0000_0001);
    wr(A_WDCTL, 32'h0000_0202);
    rd_chk(A_WDCTL, 32'hFFFF_FFFF, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      wait_cyc(200);
      wr(A_WDSVC, 32'(SVC_ARM));
      wr(A_WDSVC, 32'(SVC_FIRE));
    end
    wr(A_WDSVC, 32'(SVC_FIRE));
    chk32(n_wdr, 32'h0000_0000);
    wait_wdr(600);
    rd_chk(A_STAT, 32'h0000_000F, 32'h0000_0001);
    @(negedge mclk);
    chk1(irq, 1'b1);
    wr(A_IRQCLR, 32'h0000_000F);
    wr(A_WDSVC, 32'h0000_003C);
    wait_wdr(5);
    rd_chk(A_STAT, 32'h0000_000F, 32'h0000_0002);
    // early service in window mode
    do_reset(1'b1, 1'b0, 3'h0, 1'b0);
    wr(A_WDCTL, 32'h0000_0081);
    wr(A_WDSVC, 32'(SVC_ARM));
    wait_wdr(5);
    rd_chk(A_STAT, 32'h0000_000F, 32'h0000_0004);
    // preload, then off code refused as new period
    do_reset(1'b1, 1'b1, 3'h2, 1'b1);
    rd_chk(A_WDCTL, 32'hFFFF_FFFF, 32'h0000_0082);
    wr(A_WDCTL, 32'h0000_0000);
    rd_chk(A_WDCTL, 32'hFFFF_FFFF, 32'h0000_0002);
    // outside normal mode every period code may be written
    do_reset(1'b0, 1'b0, 3'h0, 1'b0);
    for (int c = 0; c < 8; c++) begin
      wr(A_WDCTL, 32'(c));
      rd_chk(A_WDCTL, 32'h0000_0007, 32'(c));
    end
    conclude();
  end
endmodule // pll_and_window_watchdog_bench
